/* bench/test_pattern_and_digital_gain_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module test_pattern_and_digital_gain_bench;
  logic        clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r, out_word_a_o, out_word_b_o;
  logic [3:0]  pstrb_i = 0;
  logic        pready_o, pslverr_o, e, sample_valid_i = 0, decim_tick_i = 0;
  logic [15:0] chan_a_data_i = 0, chan_b_data_i = 0;
  logic        sample_ready_o, out_valid_o, out_ready_i, slow = 0, stop = 0;
  logic [19:0] v = 20'habcde;
  logic [15:0] smp[4] = '{16'h7fff, 16'h8000, 16'h1234, 16'hff00};
  int          bad_count = 0, n_compared = 0, cyc = 0;
  test_pattern_and_digital_gain DUT (.*);
  tpg_sink u_sink (.clk_i, .nrst_i, .valid_i(out_valid_o), .ready_o(out_ready_i),
    .word_a_i(out_word_a_o), .word_b_i(out_word_b_o), .slow_i(slow), .stop_i(stop));
  initial
    forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (++cyc == 20000)
    begin
      bad_count++;
      results;
    end
  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input bit w, input logic [9:0] i, input logic [7:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    pstrb_i <= 4'h1;
    paddr_i <= {i, 2'b00};
    pwdata_i <= {24'h0, d};
    @(posedge clk_i);
    penable_i <= 1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic pushn(input int n, input bit dec);
    for (int k = 0; k < n; k++)
    begin
      sample_valid_i <= !dec;
      decim_tick_i <= dec;
      chan_a_data_i <= smp[k % 4];
      chan_b_data_i <= smp[(k + 1) % 4];
      @(posedge clk_i);
    end
    sample_valid_i <= 0;
    decim_tick_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic get(input int n);
    int w = 0;
    while (u_sink.qa.size() < n && w++ < 500)
      @(posedge clk_i);
    chk(u_sink.qa.size(), n);
  endtask
  function automatic logic [15:0] gn(input logic [15:0] d, input logic [7:0] g);
    int p;
    p = ($signed(d) * (128 + $signed(g))) >>> 7;
    gn = p > 32767 ? 16'h7fff : p < -32768 ? 16'h8000 : p[15:0];
  endfunction
  task automatic t_regs;
    logic [9:0] ix[6] = '{10'h14a, 10'h14b, 10'h14c, 10'h14d, 10'h15b, 10'h15c};
    logic [7:0] mk[6] = '{8'h17, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
    for (int k = 0; k < 6; k++)
    begin
      apb(0, ix[k], 0);
      chk(r, 0);
      apb(1, ix[k], 8'hff);
      apb(0, ix[k], 0);
      chk(r, mk[k]);
      apb(1, ix[k], 0);
    end
    apb(0, 10'h100, 0);
    chk(e, 1);
  endtask
  task automatic t_data;
    logic [2:0] ty[3] = '{0, 3, 7};
    apb(1, 10'h15b, 8'h7f);
    apb(1, 10'h15c, 8'h80);
    foreach (ty[j])
    begin
      apb(1, 10'h14a, ty[j]);
      pushn(4, 0);
      get(4);
      for (int k = 0; k < 4; k++)
      begin
        chk(u_sink.qa.pop_front(), {16'h0, gn(smp[k], 8'h7f)});
        chk(u_sink.qb.pop_front(), {16'h0, gn(smp[(k + 1) % 4], 8'h80)});
      end
    end
    // Wide resolution puts the gained sample in the upper half
    apb(1, 10'h162, 8'h02);
    apb(1, 10'h14a, 0);
    pushn(1, 0);
    get(1);
    chk(u_sink.qa.pop_front(), {gn(smp[0], 8'h7f), 16'h0});
    chk(u_sink.qb.pop_front(), {gn(smp[1], 8'h80), 16'h0});
  endtask
  task automatic t_pat(input logic [2:0] t, input bit w);
    logic [19:0] p;
    logic [31:0] x;
    apb(1, 10'h14a, 0);
    apb(1, 10'h162, {w, 1'b0});
    apb(1, 10'h14a, t);
    pushn(6, 0);
    get(6);
    for (int k = 0; k < 6; k++)
    begin
      case (t)
        1: p = k;
        2: p = v * k;
        4: p = v;
        5: p = k[0] ? ~v : v;
        default: p = k[0] ? 20'h0 : v;
      endcase
      x = w ? {p, 12'h0} : {16'h0, p[19:4]};
      chk(u_sink.qa.pop_front(), x);
      chk(u_sink.qb.pop_front(), x);
    end
  endtask
  task automatic t_fill;
    apb(1, 10'h14a, 0);
    apb(1, 10'h162, 8'h02);
    apb(1, 10'h14a, 1);
    stop <= 1;
    pushn(16, 0);
    chk(sample_ready_o, 0);
    // Tick into a full FIFO is lost and must not step the ramp
    pushn(1, 0);
    stop <= 0;
    get(16);
    for (int k = 0; k < 16; k++)
      chk(u_sink.qa.pop_front(), {k[19:0], 12'h0});
    pushn(1, 0);
    get(1);
    chk(u_sink.qa.pop_front(), {20'h10, 12'h0});
    u_sink.qb.delete();
  endtask
  task automatic t_clk;
    apb(1, 10'h14a, 0);
    apb(1, 10'h162, 0);
    apb(1, 10'h14a, 8'h14);
    pushn(3, 0);
    repeat (3) @(posedge clk_i);
    chk(u_sink.qa.size(), 0);
    pushn(2, 1);
    get(2);
    for (int k = 0; k < 2; k++)
    begin
      chk(u_sink.qa.pop_front(), {16'h0, v[19:4]});
      chk(u_sink.qb.pop_front(), {16'h0, v[19:4]});
    end
  endtask
  task automatic t_rst;
    apb(1, 10'h14a, 8'h04);
    stop <= 1;
    pushn(3, 0);
    // Reset in mid-run must empty the FIFO and clear the pattern setup
    nrst_i <= 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    stop <= 0;
    @(posedge clk_i);
    chk(out_valid_o, 0);
    chk(sample_ready_o, 1);
    apb(0, 10'h14a, 0);
    chk(r, 0);
    repeat (4) @(posedge clk_i);
    chk(u_sink.qa.size(), 0);
  endtask
  initial
  begin
    static logic [2:0] pt[5] = '{1, 2, 4, 5, 6};
    repeat (5) @(posedge clk_i);
    nrst_i <= 1;
    t_regs;
    apb(1, 10'h14b, v[7:0]);
    apb(1, 10'h14c, v[15:8]);
    apb(1, 10'h14d, {4'h0, v[19:16]});
    t_data;
    slow <= 1;
    foreach (pt[j])
    begin
      t_pat(pt[j], 0);
      t_pat(pt[j], 1);
    end
    slow <= 0;
    t_fill;
    t_clk;
    t_rst;
    results;
  end
endmodule
bind test_pattern_and_digital_gain tpg_chk u_chk (.*);
`default_nettype wire

/* bench/tpg_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_chk (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic        sample_valid_i,
  input wire logic        decim_tick_i,
  input wire logic        sample_ready_o,
  input wire logic        out_valid_o,
  input wire logic        out_ready_i,
  input wire logic [31:0] out_word_a_o,
  input wire logic [31:0] out_word_b_o
);
  logic [3:0] ctl;
  logic       wide;
  wire        pop = out_valid_o && out_ready_i;
  // Types 011 and 111 both count as generator off
  wire        pon = ctl[2:0] != 3'h0 && ctl[1:0] != 2'h3;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  always @(posedge clk_i)
  begin
    if (!nrst_i)
      {ctl, wide} <= 5'h00;
    else if (psel_i && penable_i && pwrite_i && pstrb_i[0])
    begin
      if (paddr_i == 12'h528)
        ctl <= {pwdata_i[4], pwdata_i[2:0]};
      if (paddr_i == 12'h588)
        wide <= pwdata_i[1];
    end
  end
  a_narrow_pad: assert property (out_valid_o && !wide |-> out_word_a_o[31:16] == 16'h0)
    else $error("narrow word upper half set");
  a_wide_pad: assert property (out_valid_o && wide && pon |-> out_word_a_o[11:0] == 12'h0)
    else $error("wide pattern low bits set");
  a_pat_same: assert property (out_valid_o && pon |-> out_word_a_o == out_word_b_o)
    else $error("pattern differs between channels");
  a_sample_tick: assert property (pon && !ctl[3] && sample_valid_i && sample_ready_o
    |=> out_valid_o) else $error("sample tick not pushed");
  a_decim_gate: assert property (pon && ctl[3] && !decim_tick_i && !out_valid_o
    |=> !out_valid_o) else $error("push without decimation tick");
  a_static_hold: assert property (ctl[2:0] == 3'h4 && pop ##1 out_valid_o
    |-> out_word_a_o == $past(out_word_a_o)) else $error("static word changed");
  a_invert_pair: assert property (ctl[2:0] == 3'h5 && !wide && pop ##1 out_valid_o
    |-> out_word_a_o[15:0] == ~$past(out_word_a_o[15:0])) else $error("no inversion");
  a_ramp_step: assert property (ctl[2:0] == 3'h1 && wide && pop ##1 out_valid_o
    |-> out_word_a_o[31:12] == $past(out_word_a_o[31:12]) + 20'h1) else $error("ramp step");
  cover property (pop && ctl[2:0] == 3'h5);
  cover property (!sample_ready_o);
  cover property (ctl[3] && decim_tick_i);
endmodule
`default_nettype wire

/* bench/tpg_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module tpg_sink (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        valid_i,
  output var  logic        ready_o,
  input  wire logic [31:0] word_a_i,
  input  wire logic [31:0] word_b_i,
  input  wire logic        slow_i,
  input  wire logic        stop_i
);
  logic [31:0] qa[$];
  logic [31:0] qb[$];
  logic [1:0]  cnt = 2'h0;
  // Slow mode takes one word in four cycles so the FIFO backs up
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
    begin
      qa.push_back(word_a_i);
      qb.push_back(word_b_i);
    end
    cnt <= cnt + 2'h1;
    ready_o <= nrst_i && !stop_i && (!slow_i || cnt == 2'h0);
  end
endmodule
`default_nettype wire

/* hw/sample_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             nrst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output reg  [AW:0]      level_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  wire            push;
  wire            pop;

  assign in_ready_o  = (level_o != DEPTH[AW:0]);
  assign out_valid_o = (level_o != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rd_ptr];

  always @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr  <= {AW{1'b0}};
      rd_ptr  <= {AW{1'b0}};
      level_o <= {(AW+1){1'b0}};
    end
    else
    begin
      // Pointers wrap only for power-of-two depth
      if (push)
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        level_o <= level_o + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        level_o <= level_o - {{AW{1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

/* hw/test_pattern_and_digital_gain.v */
// Operation
// [R01] Pattern steps on sample ticks when clock select is 0, decimation ticks when 1.
// [R02] Type 000, the reset value, disables the generator and passes converter data.
// [R03] Every generated pattern word is built at 20 bits.
// [R04] Narrow resolution sends the 16 upper bits of the 20-bit pattern.
// [R05] Wide resolution appends 12 zero bits below the 20-bit pattern.
// [R06] Type 001 ramps by one at 20-bit level per pattern step.
// [R07] Type 010 ramps by the programmable pattern value per step.
// [R08] Type 100 outputs the programmable pattern value constantly.
// [R09] Type 101 alternates between pattern value and its bitwise inverse.
// [R10] Type 110 alternates between pattern value and zero.
// [R11] Pattern value spans three byte registers; top register upper nibble is zero.
// [R12] Channel A data scaled by 1 + G/128, G two's-complement gain word.
// [R13] Channel B data scaled by 1 + G/128, G two's-complement gain word.
// [R14] One resolution bit selects 16-bit or 32-bit words and pattern formatting.
// [R15] Unused types 011 and 111 behave as generator disabled.
// [R16] Software writes zero to reserved bits of pattern registers.
`timescale 1ns/1ps
`default_nettype none
`include "tpg_defines.vh"

module test_pattern_and_digital_gain #(
  parameter PADDR_W    = 12,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire               clk_i,
  input  wire               nrst_i,
  input  wire               psel_i,
  input  wire               penable_i,
  input  wire               pwrite_i,
  input  wire [PADDR_W-1:0] paddr_i,
  input  wire [31:0]        pwdata_i,
  input  wire [3:0]         pstrb_i,
  output reg  [31:0]        prdata_o,
  output wire               pready_o,
  output wire               pslverr_o,
  input  wire               sample_valid_i,
  input  wire               decim_tick_i,
  input  wire [15:0]        chan_a_data_i,
  input  wire [15:0]        chan_b_data_i,
  output wire               sample_ready_o,
  output wire               out_valid_o,
  input  wire               out_ready_i,
  output wire [31:0]        out_word_a_o,
  output wire [31:0]        out_word_b_o
);

  reg  [7:0]             pattern_control;
  reg  [7:0]             pattern_value_low;
  reg  [7:0]             pattern_value_mid;
  reg  [7:0]             pattern_value_high;
  reg  [7:0]             gain_channel_a;
  reg  [7:0]             gain_channel_b;
  reg  [7:0]             output_config;
  reg  [`TPG_PAT_W-1:0]  ramp_acc;
  reg                    toggle_phase;
  reg  [`TPG_PAT_W-1:0]  gen_word;
  reg                    gen_on;
  reg  [7:0]             rd_mux;
  reg                    addr_hit;
  wire [`TPG_PAT_W-1:0]  pattern_value_word;
  wire [2:0]             pattern_type;
  wire                   decimation_path;
  wire                   wide_output_select;
  wire [9:0]             reg_index;
  wire                   apb_setup;
  wire                   apb_write;
  wire                   lane0_wr;
  wire                   stream_tick;
  wire                   push_ok;
  wire [15:0]            gained [0:1];
  wire [31:0]            word_a;
  wire [31:0]            word_b;
  wire [63:0]            fifo_out;
  wire [FIFO_AW:0]       fifo_level;

  assign pattern_value_word = {pattern_value_high[3:0], pattern_value_mid,
                               pattern_value_low}; // R11
  assign pattern_type       = pattern_control[`TPG_TYPE_MSB:0];
  assign decimation_path    = pattern_control[`TPG_CLK_SEL_BIT];
  assign wide_output_select = output_config[`TPG_WIDE_BIT]; // R14

  // APB slave: zero wait states, error on unmapped or misaligned address
  assign reg_index = paddr_i[11:2];
  assign apb_setup = psel_i & ~penable_i;
  assign apb_write = psel_i & penable_i & pwrite_i & ~pslverr_o;
  assign lane0_wr  = apb_write & pstrb_i[0];
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & (~addr_hit | (paddr_i[1:0] != 2'b00));

  always @*
  begin
    addr_hit = 1'b1;
    rd_mux   = 8'h00;
    case (reg_index)
      `TPG_IDX_CTRL:     rd_mux = pattern_control;
      `TPG_IDX_VAL_LOW:  rd_mux = pattern_value_low;
      `TPG_IDX_VAL_MID:  rd_mux = pattern_value_mid;
      `TPG_IDX_VAL_HIGH: rd_mux = pattern_value_high;
      `TPG_IDX_GAIN_A:   rd_mux = gain_channel_a;
      `TPG_IDX_GAIN_B:   rd_mux = gain_channel_b;
      `TPG_IDX_OUT_CFG:  rd_mux = output_config;
      `TPG_IDX_STATUS:   rd_mux = 8'h00;
      default:           addr_hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle so it comes from a flop
  always @(posedge clk_i)
  begin
    if (!nrst_i)
      prdata_o <= 32'h00000000;
    else if (apb_setup && !pwrite_i)
    begin
      if (reg_index == `TPG_IDX_STATUS)
        prdata_o <= {{(32-`TPG_STAT_LVL_LSB-FIFO_AW-1){1'b0}}, fifo_level, ramp_acc};
      else
        prdata_o <= {24'h000000, rd_mux};
    end
  end

  // Reserved bits are masked so they read as zero even if written
  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pattern_control    <= `TPG_CTRL_RST; // R02
      pattern_value_low  <= `TPG_VAL_RST;
      pattern_value_mid  <= `TPG_VAL_RST;
      pattern_value_high <= `TPG_VAL_RST;
      gain_channel_a     <= `TPG_GAIN_RST;
      gain_channel_b     <= `TPG_GAIN_RST;
      output_config      <= `TPG_OUT_CFG_RST;
    end
    else if (lane0_wr)
    begin
      case (reg_index)
        `TPG_IDX_CTRL:     pattern_control    <= pwdata_i[7:0] & `TPG_CTRL_MASK; // R16
        `TPG_IDX_VAL_LOW:  pattern_value_low  <= pwdata_i[7:0];
        `TPG_IDX_VAL_MID:  pattern_value_mid  <= pwdata_i[7:0];
        `TPG_IDX_VAL_HIGH: pattern_value_high <= pwdata_i[7:0] & `TPG_HIGH_MASK; // R11
        `TPG_IDX_GAIN_A:   gain_channel_a     <= pwdata_i[7:0];
        `TPG_IDX_GAIN_B:   gain_channel_b     <= pwdata_i[7:0];
        `TPG_IDX_OUT_CFG:  output_config      <= pwdata_i[7:0] & `TPG_OUT_CFG_MASK;
        default:           output_config      <= output_config;
      endcase
    end
  end

  // Pattern source select
  always @*
  begin
    gen_on   = 1'b1;
    gen_word = `TPG_PAT_ZERO;
    case (pattern_type)
      `TPG_TYPE_RAMP1:  gen_word = ramp_acc; // R06
      `TPG_TYPE_RAMPV:  gen_word = ramp_acc; // R07
      `TPG_TYPE_STATIC: gen_word = pattern_value_word; // R08
      `TPG_TYPE_INVERT: gen_word = toggle_phase ? ~pattern_value_word
                                                : pattern_value_word; // R09
      `TPG_TYPE_ZERO:   gen_word = toggle_phase ? `TPG_PAT_ZERO
                                                : pattern_value_word; // R10
      default:          gen_on   = 1'b0; // R02 R15
    endcase
  end

  // Generator steps on the selected tick, only when the FIFO takes the word
  assign stream_tick = (gen_on && decimation_path) ? decim_tick_i : sample_valid_i; // R01
  assign push_ok     = stream_tick & sample_ready_o;

  always @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ramp_acc     <= `TPG_PAT_ZERO;
      toggle_phase <= 1'b0;
    end
    else if (!gen_on)
    begin
      // Restart cleanly whenever a pattern is next enabled
      ramp_acc     <= `TPG_PAT_ZERO;
      toggle_phase <= 1'b0;
    end
    else if (push_ok)
    begin
      toggle_phase <= ~toggle_phase;
      if (pattern_type == `TPG_TYPE_RAMP1)
        ramp_acc <= ramp_acc + `TPG_RAMP_UNIT; // R06 R03
      else if (pattern_type == `TPG_TYPE_RAMPV)
        ramp_acc <= ramp_acc + pattern_value_word; // R07 R03
    end
  end

  // Per-channel gain; saturates since 1 + G/128 can nearly double a sample
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : gain_stage
      wire signed [15:0] din;
      wire signed [8:0]  gmul;
      wire signed [24:0] prod;
      wire signed [24:0] scaled;
      wire signed [16:0] trunc;
      assign din    = (ch == 0) ? chan_a_data_i : chan_b_data_i;
      assign gmul   = `TPG_GAIN_UNITY + ((ch == 0) ? {gain_channel_a[7], gain_channel_a}
                                                  : {gain_channel_b[7], gain_channel_b});
      assign prod   = din * gmul; // R12 R13
      assign scaled = prod >>> `TPG_GAIN_SHIFT;
      assign trunc  = scaled[16:0];
      assign gained[ch] = (trunc[16] != trunc[15]) ?
                          (trunc[16] ? `TPG_SAT_NEG : `TPG_SAT_POS) : trunc[15:0];
    end
  endgenerate

  // Output formatting by resolution
  assign word_a = gen_on ?
                  (wide_output_select ? {gen_word, `TPG_PAD12} // R05
                                      : {`TPG_PAD16, gen_word[19:4]}) : // R04
                  (wide_output_select ? {gained[0], `TPG_PAD16}
                                      : {`TPG_PAD16, gained[0]}); // R14
  assign word_b = gen_on ?
                  (wide_output_select ? {gen_word, `TPG_PAD12} // R05
                                      : {`TPG_PAD16, gen_word[19:4]}) : // R04
                  (wide_output_select ? {gained[1], `TPG_PAD16}
                                      : {`TPG_PAD16, gained[1]}); // R14

  sample_fifo #(
    .WIDTH (64),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (stream_tick),
    .in_ready_o  (sample_ready_o),
    .in_data_i   ({word_b, word_a}),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out),
    .level_o     (fifo_level)
  );

  assign out_word_a_o = fifo_out[31:0];
  assign out_word_b_o = fifo_out[63:32];

endmodule

`default_nettype wire

/* hw/tpg_defines.vh */
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// Register word indices; byte address is four times the index
`define TPG_IDX_CTRL      10'h14a
`define TPG_IDX_VAL_LOW   10'h14b
`define TPG_IDX_VAL_MID   10'h14c
`define TPG_IDX_VAL_HIGH  10'h14d
`define TPG_IDX_GAIN_A    10'h15b
`define TPG_IDX_GAIN_B    10'h15c
`define TPG_IDX_OUT_CFG   10'h162
`define TPG_IDX_STATUS    10'h170

// Field positions and write masks
`define TPG_CTRL_MASK     8'h17
`define TPG_CLK_SEL_BIT   4
`define TPG_TYPE_MSB      2
`define TPG_HIGH_MASK     8'h0f
`define TPG_OUT_CFG_MASK  8'h02
`define TPG_WIDE_BIT      1
`define TPG_STAT_LVL_LSB  20

// Reset values
`define TPG_CTRL_RST      8'h00
`define TPG_VAL_RST       8'h00
`define TPG_GAIN_RST      8'h00
`define TPG_OUT_CFG_RST   8'h00

// Pattern type codes
`define TPG_TYPE_OFF      3'b000
`define TPG_TYPE_RAMP1    3'b001
`define TPG_TYPE_RAMPV    3'b010
`define TPG_TYPE_STATIC   3'b100
`define TPG_TYPE_INVERT   3'b101
`define TPG_TYPE_ZERO     3'b110

// Widths and constants of the data path
`define TPG_PAT_W         20
`define TPG_PAT_ZERO      20'h00000
`define TPG_RAMP_UNIT     20'h00001
`define TPG_PAD12         12'h000
`define TPG_PAD16         16'h0000
`define TPG_GAIN_UNITY    9'h080
`define TPG_GAIN_SHIFT    7
`define TPG_SAT_POS       16'h7fff
`define TPG_SAT_NEG       16'h8000

`endif
